// *** design/issx_exec.sv ***
// Purpose: Decode and execute for shift, subtract, store, sys, trap, xor
// Assumes: One instruction per issue pulse
// Notes:   Results and requests are registered one cycle after issue
`timescale 1ns/1ps
module issx_exec
	import issx_pkg::*;
#(
	parameter int XLEN = 32
) (
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              srst_i,
	// Issue from the pipeline
	input  wire logic              issue_i,
	input  wire logic [31:0]       insn_i,
	input  wire logic [XLEN-1:0]   src_a_i,
	input  wire logic [XLEN-1:0]   src_b_i,
	input  wire logic [XLEN-1:0]   pc_i,
	// Status and control bits
	input  wire logic              range_trap_enable_i,
	input  wire logic              signed_wrap_trap_en_i,
	input  wire logic              borrow_trap_en_i,
	input  wire logic              translation_on_i,
	input  wire logic [XLEN-1:0]   supervision_reg_i,
	// Reservation and translation
	input  wire logic              resv_valid_i,
	input  wire logic [XLEN-1:0]   resv_addr_i,
	input  wire logic [XLEN-1:0]   phys_addr_i,
	input  wire issx_mem_fault_t   mem_fault_i,
	// Register write-back
	output logic                   wb_valid_o,
	output logic [4:0]             wb_dest_o,
	output logic [XLEN-1:0]        wb_data_o,
	// Flags
	output logic                   unsigned_borrow_bit_o,
	output logic                   signed_wrap_bit_o,
	output logic                   comparison_result_bit_o,
	output logic                   flag_we_o,
	// Data memory
	output logic                   store_req_o,
	output logic [XLEN-1:0]        effective_address_o,
	output logic [STORE_W-1:0]     store_data_o,
	// Exceptions
	output issx_exc_req_t          exc_o,
	output logic [XLEN-1:0]        exc_return_pc_o,
	output logic                   trap_bit_hit_o
);
	// ============================================================
	// Decode
	issx_op_t          op;
	logic [XLEN-1:0]   shift_res;
	logic [5:0]        shift_amt;
	logic [XLEN-1:0]   imm16_sx;
	logic [XLEN-1:0]   split_sx;
	logic [XLEN-1:0]   ea_next;
	logic [XLEN:0]     diff;
	logic              borrow_next;
	logic              wrap_next;
	logic [XLEN-1:0]   cmp_addr;
	logic              atomic_ok;

	// ============================================================
	// Operation classes, shared by write-back, flags and checks
	function automatic logic writes_reg(input issx_op_t o);
		return (o == OP_SRL) || (o == OP_SRLI) || (o == OP_SUB) ||
		       (o == OP_XOR) || (o == OP_XORI);
	endfunction

	function automatic logic sets_flag(input issx_op_t o);
		return (o == OP_SUB) || (o == OP_SWA);
	endfunction

	function automatic logic is_store(input issx_op_t o);
		return (o == OP_SW) || (o == OP_SWA);
	endfunction

	issx_decode u_dec (
		.insn_i (insn_i),
		.op_o   (op)
	);

	// Immediate form takes its count from the word, register form from source two
	assign shift_amt = (op == OP_SRLI) ? insn_i[5:0] : src_b_i[5:0]; // [RL2] [RL3]

	issx_shifter #(.XLEN(XLEN)) u_shf (
		.src_i (src_a_i),
		.amt_i (shift_amt),
		.res_o (shift_res)
	);

	// ============================================================
	// Arithmetic and address
	assign imm16_sx    = XLEN'($signed(insn_i[15:0]));                    // [RL16]
	assign split_sx    = XLEN'($signed({insn_i[25:21], insn_i[10:0]}));  // [RL8]
	assign ea_next     = src_a_i + split_sx;                               // [RL8]
	assign diff        = {1'b0, src_a_i} - {1'b0, src_b_i};
	assign borrow_next = diff[XLEN];                                       // [RL6]
	assign wrap_next   = (src_a_i[XLEN-1] != src_b_i[XLEN-1]) &&
	                     (diff[XLEN-1] != src_a_i[XLEN-1]);                // [RL6]
	// Physical compare when translation is on; caller supplies the translation
	assign cmp_addr    = translation_on_i ? phys_addr_i : ea_next;         // [RL11]
	assign atomic_ok   = resv_valid_i && (resv_addr_i == cmp_addr);        // [RL10]

	// ============================================================
	// Write-back
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			wb_valid_o <= 1'b0;
			wb_dest_o  <= 5'h00;
			wb_data_o  <= '0;
		end else begin
			wb_valid_o <= issue_i && writes_reg(op);
			wb_dest_o  <= insn_i[25:21];
			case (op)
				OP_SRL, OP_SRLI: wb_data_o <= shift_res;            // [RL2] [RL18]
				OP_SUB:          wb_data_o <= diff[XLEN-1:0];       // [RL5]
				OP_XOR:          wb_data_o <= src_a_i ^ src_b_i;    // [RL15] [RL17]
				OP_XORI:         wb_data_o <= src_a_i ^ imm16_sx;   // [RL16]
				default:         wb_data_o <= '0;
			endcase
		end
	end

	// ============================================================
	// Flags
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			unsigned_borrow_bit_o   <= FLAG_RST;
			signed_wrap_bit_o       <= FLAG_RST;
			comparison_result_bit_o <= FLAG_RST;
			flag_we_o               <= 1'b0;
		end else begin
			flag_we_o <= issue_i && sets_flag(op);
			// Flags are levels; only their own instruction may move them
			if (issue_i && op == OP_SUB) begin
				unsigned_borrow_bit_o <= borrow_next; // [RL6]
				signed_wrap_bit_o     <= wrap_next;   // [RL6]
			end
			if (issue_i && op == OP_SWA) begin
				comparison_result_bit_o <= atomic_ok; // [RL10]
			end
		end
	end

	// ============================================================
	// Store port
	logic mem_fault_any;
	logic misaligned;
	assign mem_fault_any = mem_fault_i.tlb_miss | mem_fault_i.page_fault | mem_fault_i.bus_error;
	// Word stores need a word-aligned address; no split access is attempted
	assign misaligned    = ea_next[1:0] != 2'h0;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			store_req_o         <= 1'b0;
			effective_address_o <= '0;
			store_data_o        <= '0;
		end else begin
			// Faulting stores never reach memory
			store_req_o <= issue_i && !mem_fault_any && !misaligned &&
			               (op == OP_SW || (op == OP_SWA && atomic_ok)); // [RL8] [RL10]
			effective_address_o <= ea_next;                              // [RL8]
			store_data_o        <= src_b_i[STORE_W-1:0];                 // [RL8] [RL17]
		end
	end

	// ============================================================
	// Exceptions, fixed priority: memory faults, then misalignment
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			exc_o           <= '{valid: 1'b0, code: EXC_NONE, imm: 16'h0000};
			exc_return_pc_o <= '0;
			trap_bit_hit_o  <= 1'b0;
		end else begin
			exc_o           <= '{valid: 1'b0, code: EXC_NONE, imm: insn_i[15:0]};
			exc_return_pc_o <= pc_i;
			trap_bit_hit_o  <= 1'b0;
			if (issue_i) begin
				case (op)
					OP_SW, OP_SWA: begin
						if (mem_fault_i.tlb_miss) begin
							exc_o.valid <= 1'b1;
							exc_o.code  <= EXC_TLB;   // [RL9]
						end else if (mem_fault_i.page_fault) begin
							exc_o.valid <= 1'b1;
							exc_o.code  <= EXC_PAGE;  // [RL9]
						end else if (mem_fault_i.bus_error) begin
							exc_o.valid <= 1'b1;
							exc_o.code  <= EXC_BUS;   // [RL9]
						end else if (misaligned) begin
							exc_o.valid <= 1'b1;
							exc_o.code  <= EXC_ALIGN; // [RL9]
						end
					end
					OP_SUB: begin
						if (range_trap_enable_i && ((wrap_next && signed_wrap_trap_en_i) ||
						    (borrow_next && borrow_trap_en_i))) begin
							exc_o.valid <= 1'b1;
							exc_o.code  <= EXC_RANGE; // [RL7]
						end
					end
					OP_SYS: begin
						exc_o.valid     <= 1'b1;
						exc_o.code      <= EXC_SYSCALL;                      // [RL12]
						exc_return_pc_o <= pc_i + XLEN'(4);                  // [RL13]
					end
					OP_TRAP: begin
						exc_o.valid    <= 1'b1;
						exc_o.code     <= EXC_TRAP;                          // [RL14]
						trap_bit_hit_o <= supervision_reg_i[insn_i[$clog2(XLEN)-1:0]]; // [RL14]
					end
					default: ;
				endcase
			end
		end
	end

	// ============================================================
	// Checks on results
	AST_SUB_RESULT: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL5]
		issue_i && op == OP_SUB |=> wb_valid_o && wb_data_o == $past(src_a_i) - $past(src_b_i))
		else $error("subtract result wrong");
	AST_SRL_RESULT: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL18]
		issue_i && op == OP_SRL && src_b_i[4:0] == 5'h00 && XLEN == 32 |=> wb_data_o == $past(src_a_i))
		else $error("zero shift changed value");
	AST_SRL_FILL: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL2]
		issue_i && op == OP_SRL && src_b_i[4:0] != 5'h00 |=> !wb_data_o[XLEN-1])
		else $error("register shift did not zero fill");
	AST_SRLI_FILL: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL3]
		issue_i && op == OP_SRLI && insn_i[4:0] != 5'h00 |=> !wb_data_o[XLEN-1])
		else $error("immediate shift did not zero fill");
	AST_SRLI_ZERO: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL18]
		issue_i && op == OP_SRLI && insn_i[4:0] == 5'h00 && XLEN == 32 |=> wb_data_o == $past(src_a_i))
		else $error("zero immediate shift changed value");
	AST_XOR: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL15]
		issue_i && op == OP_XOR |=> wb_valid_o && wb_data_o == ($past(src_a_i) ^ $past(src_b_i)))
		else $error("xor result wrong");
	AST_XORI: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL16]
		issue_i && op == OP_XORI |=> wb_data_o == ($past(src_a_i) ^ XLEN'($signed($past(insn_i[15:0])))))
		else $error("xor immediate wrong");
	AST_WB_DEST: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL5]
		issue_i && writes_reg(op) |=> wb_valid_o && wb_dest_o == $past(insn_i[25:21]))
		else $error("destination register wrong");

	// ============================================================
	// Checks on flags
	AST_BORROW: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL6]
		issue_i && op == OP_SUB |=> unsigned_borrow_bit_o == ($past(src_a_i) < $past(src_b_i)))
		else $error("borrow flag wrong");
	AST_WRAP: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL6]
		issue_i && op == OP_SUB |=> signed_wrap_bit_o ==
		(wb_data_o[XLEN-1] != ($signed($past(src_a_i)) < $signed($past(src_b_i)))))
		else $error("signed wrap flag wrong");
	AST_FLAG_HOLD: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL6]
		!(issue_i && op == OP_SUB) |=> $stable(unsigned_borrow_bit_o) && $stable(signed_wrap_bit_o))
		else $error("flags moved without a subtract");
	AST_CMP_HOLD: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL10]
		!(issue_i && op == OP_SWA) |=> $stable(comparison_result_bit_o))
		else $error("compare flag moved without an atomic store");
	AST_RANGE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL7]
		issue_i && op == OP_SUB && !range_trap_enable_i |=> exc_o.code != EXC_RANGE)
		else $error("range exception without enable");
	AST_RANGE_FIRE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL7]
		issue_i && op == OP_SUB && range_trap_enable_i && borrow_trap_en_i && src_a_i < src_b_i
		|=> exc_o.valid && exc_o.code == EXC_RANGE)
		else $error("range exception on borrow missing");
	AST_RANGE_WRAP: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL7]
		issue_i && op == OP_SUB && range_trap_enable_i && signed_wrap_trap_en_i ##1 signed_wrap_bit_o
		|-> exc_o.valid && exc_o.code == EXC_RANGE)
		else $error("range exception on signed wrap missing");

	// ============================================================
	// Checks on stores and exceptions
	AST_SWA_GATE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL10]
		issue_i && op == OP_SWA && !atomic_ok |=> !store_req_o && !comparison_result_bit_o)
		else $error("atomic store without reservation");
	AST_SWA_OK: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL10]
		issue_i && op == OP_SWA && atomic_ok && !mem_fault_any && ea_next[1:0] == 2'h0
		|=> store_req_o && comparison_result_bit_o)
		else $error("atomic store with reservation not done");
	AST_SW_DATA: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL8]
		store_req_o |-> store_data_o == $past(src_b_i[31:0]))
		else $error("store data wrong");
	AST_SW_REQ: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL8]
		issue_i && op == OP_SW && !mem_fault_any && ea_next[1:0] == 2'h0
		|=> store_req_o && !exc_o.valid)
		else $error("clean store not requested");
	AST_STORE_NO_WB: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL8]
		issue_i && is_store(op) |=> !wb_valid_o)
		else $error("store wrote a register");
	AST_FAULT_NO_STORE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL9]
		issue_i && is_store(op) &&
		(mem_fault_i.tlb_miss || mem_fault_i.page_fault || mem_fault_i.bus_error)
		|=> exc_o.valid && !store_req_o)
		else $error("faulting store reached memory");
	AST_FAULT_TLB: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL9]
		issue_i && is_store(op) && mem_fault_i.tlb_miss |=> exc_o.code == EXC_TLB)
		else $error("translation miss not reported first");
	AST_ALIGN: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL9]
		issue_i && op == OP_SW && !mem_fault_any && ea_next[1:0] != 2'h0
		|=> exc_o.valid && exc_o.code == EXC_ALIGN && !store_req_o)
		else $error("misaligned store not refused");
	AST_SYS_RET: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL13]
		issue_i && op == OP_SYS |=> exc_o.valid && exc_o.code == EXC_SYSCALL &&
		exc_return_pc_o == $past(pc_i) + XLEN'(4))
		else $error("system call return point wrong");
	AST_EXC_IMM: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL12]
		issue_i && (op == OP_SYS || op == OP_TRAP) |=> exc_o.imm == $past(insn_i[15:0]) &&
		!wb_valid_o && !store_req_o)
		else $error("service code lost or side effect seen");
	AST_TRAP: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RL14]
		issue_i && insn_i[31:16] == OPC_TRAP |=> exc_o.valid && exc_o.code == EXC_TRAP)
		else $error("trap not raised");
endmodule // issx_exec

// *** design/issx_pkg.sv ***
// Purpose: Shared constants and types for the shift/sub/store/sys/xor executor
// Assumes: 32-bit instruction words, core clock 25 MHz
// Notes:   Summary of operation below
// Summary of operation
// (RL1) Register right shift: 0x38, sub 0x1, nibble 0x8
// (RL2) Shift by source two, zero fill
// (RL3) Immediate right shift: 0x2e, sub 0x1, six-bit count
// (RL4) 32-bit builds ignore immediate count bit five
// (RL5) Subtract: 0x38, sub 0x0, nibble 0x2
// (RL6) Subtract sets borrow and signed wrap flags
// (RL7) Range exception gated by trap enables
// (RL8) Store word: base plus split offset, 32 bits
// (RL9) Stores may raise memory faults
// (RL10) Atomic store writes only if reservation intact
// (RL11) Translated address compared when translation on
// (RL12) 0x2000 upper half: system call exception
// (RL13) System call returns to following instruction
// (RL14) 0x2100 upper half: trap, immediate selects bit
// (RL15) Register xor: 0x38, sub 0x0, nibble 0x5
// (RL16) Immediate xor, sign-extended sixteen-bit immediate
// (RL17) Width parameter; stores still write 32 bits
// (RL18) Zero shift count passes source unchanged
package issx_pkg;
	// ============================================================
	// Opcode fields
	localparam logic [5:0]  OPC_ALU     = 6'h38;
	localparam logic [5:0]  OPC_SHI     = 6'h2E;
	localparam logic [5:0]  OPC_SW      = 6'h35;
	localparam logic [5:0]  OPC_SWA     = 6'h33;
	localparam logic [5:0]  OPC_XORI    = 6'h2B;
	localparam logic [15:0] OPC_SYS     = 16'h2000;
	localparam logic [15:0] OPC_TRAP    = 16'h2100;
	localparam logic [3:0]  SUB_SRL     = 4'h1;
	localparam logic [3:0]  LOW_SHIFT   = 4'h8;
	localparam logic [1:0]  SUB_SRLI    = 2'h1;
	localparam logic [1:0]  SUB_ARITH   = 2'h0;
	localparam logic [3:0]  LOW_SUB     = 4'h2;
	localparam logic [3:0]  LOW_XOR     = 4'h5;
	localparam int          INSN_W      = 32;
	localparam int          STORE_W     = 32;
	localparam logic        FLAG_RST    = 1'h0;

	// ============================================================
	// Operation and exception codes
	typedef enum logic [3:0] {
		OP_NONE = 4'h0, OP_SRL = 4'h1, OP_SRLI = 4'h2, OP_SUB = 4'h3,
		OP_SW = 4'h4, OP_SWA = 4'h5, OP_SYS = 4'h6, OP_TRAP = 4'h7,
		OP_XOR = 4'h8, OP_XORI = 4'h9
	} issx_op_t;

	typedef enum logic [2:0] {
		EXC_NONE = 3'h0, EXC_RANGE = 3'h1, EXC_SYSCALL = 3'h2, EXC_TRAP = 3'h3,
		EXC_TLB = 3'h4, EXC_PAGE = 3'h5, EXC_BUS = 3'h6, EXC_ALIGN = 3'h7
	} issx_exc_t;

	typedef struct packed {
		logic             valid;
		issx_exc_t        code;
		logic [15:0]      imm;
	} issx_exc_req_t;

	typedef struct packed {
		logic tlb_miss;
		logic page_fault;
		logic bus_error;
	} issx_mem_fault_t;
endpackage

// *** design/issx_decode.sv ***
// Purpose: Instruction word to operation code
// Assumes: Purely combinational
// Notes:   Unknown words decode as no operation
`timescale 1ns/1ps
module issx_decode
	import issx_pkg::*;
(
	// Instruction
	input  wire logic [31:0] insn_i,
	// Decoded
	output issx_op_t         op_o
);
	always_comb begin
		op_o = OP_NONE;
		if (insn_i[31:16] == OPC_SYS) begin
			op_o = OP_SYS; // [RL12]
		end else if (insn_i[31:16] == OPC_TRAP) begin
			op_o = OP_TRAP; // [RL14]
		end else if (insn_i[31:26] == OPC_ALU && insn_i[9:6] == SUB_SRL && insn_i[3:0] == LOW_SHIFT) begin
			op_o = OP_SRL; // [RL1]
		end else if (insn_i[31:26] == OPC_ALU && insn_i[9:8] == SUB_ARITH && insn_i[3:0] == LOW_SUB) begin
			op_o = OP_SUB; // [RL5]
		end else if (insn_i[31:26] == OPC_ALU && insn_i[9:8] == SUB_ARITH && insn_i[3:0] == LOW_XOR) begin
			op_o = OP_XOR; // [RL15]
		end else if (insn_i[31:26] == OPC_SHI && insn_i[7:6] == SUB_SRLI) begin
			op_o = OP_SRLI; // [RL3]
		end else if (insn_i[31:26] == OPC_SW) begin
			op_o = OP_SW; // [RL8]
		end else if (insn_i[31:26] == OPC_SWA) begin
			op_o = OP_SWA; // [RL10]
		end else if (insn_i[31:26] == OPC_XORI) begin
			op_o = OP_XORI; // [RL16]
		end
	end
endmodule // issx_decode

// *** design/issx_shifter.sv ***
// Purpose: Logical right shifter, zero fill
// Assumes: XLEN of 32 or 64
// Notes:   Count bit five dropped in 32-bit builds
`timescale 1ns/1ps
module issx_shifter
	import issx_pkg::*;
#(
	parameter int XLEN = 32
) (
	// Operands
	input  wire logic [XLEN-1:0] src_i,
	input  wire logic [5:0]      amt_i,
	// Result
	output logic      [XLEN-1:0] res_o
);
	localparam int SH_W = (XLEN == 64) ? 6 : 5;
	logic [SH_W-1:0] cnt;
	assign cnt   = amt_i[SH_W-1:0];      // [RL2] [RL4]
	assign res_o = src_i >> cnt;          // [RL2] [RL18]
endmodule // issx_shifter

// *** test/issx_core_model.sv ***
// Purpose: Reservation, translation and memory fault source for the executor
// Assumes: Bench hands over the effective address it expects
// Notes:   Phys address is ea xor XMASK; without translation it shows junk
`timescale 1ns/1ps
module issx_core_model
	import issx_pkg::*;
#(
	parameter int          XLEN  = 32,
	parameter logic [31:0] XMASK = 32'h00010000
) (
	// Clock and reset
	input  wire logic            ref_clk_i,
	input  wire logic            srst_i,
	// Bench control
	input  wire logic            set_i,
	input  wire logic [XLEN-1:0] set_addr_i,
	input  wire logic [XLEN-1:0] ea_i,
	input  wire logic            xlate_i,
	input  wire logic [1:0]      fault_sel_i,
	input  wire logic            store_i,
	// Toward executor
	output logic                 resv_valid_o,
	output logic [XLEN-1:0]      resv_addr_o,
	output logic [XLEN-1:0]      phys_addr_o,
	output issx_mem_fault_t      mem_fault_o
);
	// ============================================================
	// Reservation, lost on any store so a retry must fail
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || store_i)
			resv_valid_o <= 1'b0;
		else if (set_i)
			resv_valid_o <= 1'b1;
		if (srst_i)
			resv_addr_o <= '0;
		else if (set_i)
			resv_addr_o <= set_addr_i;
	end
	// Inverse when off, so a design that uses it anyway is caught
	assign phys_addr_o = xlate_i ? (ea_i ^ XLEN'(XMASK)) : ~ea_i;
	assign mem_fault_o = '{fault_sel_i == 2'h1, fault_sel_i == 2'h2, fault_sel_i == 2'h3};
endmodule // issx_core_model

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the shift/sub/store/sys/xor executor
// Assumes: 32-bit build, answer one cycle after issue
// Notes:   Table of plain cases first, awkward cases by hand
`timescale 1ns/1ps
module testbench;
	import issx_pkg::*;
	typedef struct packed {logic [31:0] w, x, y, e;} issx_row_t;
	logic            clk, rst, iss, rte, owe, bte, xl, rv, rset, wv, cy, ov, cmp, fwe, sreq, thit;
	logic [1:0]      fsel;
	logic [4:0]      wd;
	logic [31:0]     insn, a, b, pc, sr, ra, pa, wdat, eao, sdat, rpc, ea, raddr;
	issx_mem_fault_t mf;
	issx_exc_req_t   exc;
	int              mismatches, n_checks;
	logic [31:0]     sa[4] = '{32'h5, 32'h80000000, 32'h7, 32'h7FFFFFFF};
	logic [31:0]     sb[4] = '{32'h7, 32'h1, 32'h5, 32'hFFFFFFFF};
	logic [4:0]      sf[4] = '{5'b10111, 5'b01110, 5'b00111, 5'b11011}; // borrow, wrap, enables
	issx_row_t       rows[10] = '{
		'{32'hE0611048, 32'h80000000, 32'h4, 32'h08000000}, '{32'hE0611048, 32'h8000000F, 32'h0, 32'h8000000F},
		'{32'hE0611048, 32'h80000000, 32'h24, 32'h08000000}, '{32'hE0611048, 32'hFFFFFFFF, 32'h1F, 32'h1},
		'{32'hB8610061, 32'hF0000000, 32'h5, 32'h78000000}, '{32'hB8610040, 32'h12345678, 32'h3, 32'h12345678},
		'{32'hB861005F, 32'h80000000, 32'h0, 32'h1}, '{32'hE0611002, 32'h5, 32'h7, 32'hFFFFFFFE},
		'{32'hE0611005, 32'hF0F0F0F0, 32'hFF00FF00, 32'h0FF00FF0}, '{32'hAC618001, 32'h0000FFFF, 32'h0, 32'hFFFF7FFE}};

	issx_exec #(.XLEN(32)) dut (
		.ref_clk_i(clk), .srst_i(rst), .issue_i(iss), .insn_i(insn), .src_a_i(a), .src_b_i(b), .pc_i(pc),
		.range_trap_enable_i(rte), .signed_wrap_trap_en_i(owe), .borrow_trap_en_i(bte),
		.translation_on_i(xl), .supervision_reg_i(sr), .resv_valid_i(rv), .resv_addr_i(ra),
		.phys_addr_i(pa), .mem_fault_i(mf), .wb_valid_o(wv), .wb_dest_o(wd), .wb_data_o(wdat),
		.unsigned_borrow_bit_o(cy), .signed_wrap_bit_o(ov), .comparison_result_bit_o(cmp),
		.flag_we_o(fwe), .store_req_o(sreq), .effective_address_o(eao), .store_data_o(sdat),
		.exc_o(exc), .exc_return_pc_o(rpc), .trap_bit_hit_o(thit));
	issx_core_model #(.XLEN(32)) u_model (
		.ref_clk_i(clk), .srst_i(rst), .set_i(rset), .set_addr_i(raddr), .ea_i(ea), .xlate_i(xl),
		.fault_sel_i(fsel), .store_i(sreq), .resv_valid_o(rv), .resv_addr_o(ra), .phys_addr_o(pa),
		.mem_fault_o(mf));

	// ============================================================
	// Tasks
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Issue held over one rising edge, answer read at the next falling edge
	task automatic run(input logic [31:0] w, input logic [31:0] x, input logic [31:0] y);
		@(negedge clk);
		insn = w;
		a = x;
		b = y;
		iss = 1'b1;
		@(negedge clk);
		iss = 1'b0;
	endtask
	task automatic rsv(input logic [31:0] adr);
		@(negedge clk);
		rset = 1'b1;
		raddr = adr;
		@(negedge clk);
		rset = 1'b0;
	endtask
	function automatic logic [31:0] mem(input logic [5:0] op, input logic [15:0] i);
		return {op, i[15:11], 5'h01, 5'h02, i[10:0]};
	endfunction
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ============================================================
	// Clock, watchdog, sequence
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#2000000;
		mismatches++;
		results();
	end
	initial begin
		{iss, rte, owe, bte, xl, rset, fsel} = '0;
		{insn, a, b, pc, sr, ea, raddr} = '0;
		rst = 1'b1;
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		chk({wv, fwe, sreq, exc.valid, thit, cy, ov, cmp}, 8'h0);
		foreach (rows[r]) begin
			run(rows[r].w, rows[r].x, rows[r].y);
			chk({wv, wd, wdat}, {1'b1, 5'h03, rows[r].e});
		end
		for (int i = 0; i < 4; i++) begin
			{rte, owe, bte} = sf[i][2:0];
			run(32'hE0611002, sa[i], sb[i]);
			chk({fwe, cy, ov}, {1'b1, sf[i][4:3]});
			chk(exc.valid, sf[i][2] & (sf[i][4] & sf[i][0] | sf[i][3] & sf[i][1]));
			chk(exc.valid ? exc.code : EXC_RANGE, EXC_RANGE);
		end
		ea = 32'h0FFC;
		run(mem(6'h35, 16'hFFFC), 32'h1000, 32'hCAFEF00D);
		chk({sreq, exc.valid, eao, sdat}, {2'b10, 32'hFFC, 32'hCAFEF00D});
		// Faults outrank misalignment, both store kinds
		for (int j = 0; j < 4; j++) begin
			fsel = 2'(j);
			ea = 32'h1001;
			run(mem(j[0] ? 6'h33 : 6'h35, 16'h0001), 32'h1000, 32'h0);
			chk({sreq, exc.valid, exc.code}, {2'b01, (j == 0) ? EXC_ALIGN : issx_exc_t'(3 + j)});
		end
		fsel = 2'h0;
		for (int k = 0; k < 4; k++) begin
			xl = k[1];
			if (k != 1)
				rsv((k == 2) ? 32'h12000 : 32'h2000);
			ea = 32'h2000;
			run(mem(6'h33, 16'h0000), 32'h2000, 32'h600D);
			chk({sreq, cmp}, {2{~k[0]}});
		end
		pc = 32'h100;
		run({OPC_SYS, 16'h1234}, 32'h0, 32'h0);
		chk({wv, exc}, {1'b0, 1'b1, EXC_SYSCALL, 16'h1234});
		chk(rpc, 32'h104);
		sr = 32'h8;
		for (int t = 2; t < 4; t++) begin
			run({OPC_TRAP, 16'(t)}, 32'h0, 32'h0);
			chk({exc, thit}, {1'b1, EXC_TRAP, 16'(t), t == 3});
		end
		run(32'h0, 32'h5, 32'h7);
		chk({wv, sreq, exc.valid}, 3'h0);
		// Borrow must survive an unrelated op, then a reset clears it
		run(32'hE0611002, 32'h5, 32'h7);
		run(32'hE0611005, 32'h5, 32'h7);
		chk({cy, fwe}, 2'b10);
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		chk({cy, wv}, 2'b00);
		results();
	end
endmodule // testbench
